// file: src/lafoe_core.sv
// literal and file operation executor: two-stage fetch/execute pipe,
// ahb-lite register slave, program memory and data register file ports.
// assumes program memory and register file read combinationally on the
// same clock, and the register file writes at the edge ending o_file_we.
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module lafoe_core
    import lafoe_pkg::*;
#(
    parameter int PCW   = 10,
    parameter int CNT_W = 16
)
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic [31:0]            o_hrdata,
    output logic                   o_hreadyout,
    output logic                   o_hresp,
    output logic [PCW-1:0]         o_prog_addr,
    input  wire logic [OPW-1:0]    i_prog_word,
    output logic [FAW-1:0]         o_file_raddr,
    input  wire logic [DW-1:0]     i_file_rdata,
    output logic                   o_file_we,
    output logic [FAW-1:0]         o_file_waddr,
    output logic [DW-1:0]          o_file_wdata,
    output logic [DW-1:0]          o_acc,
    output logic [2:0]             o_status
);

    // pipeline and architectural state
    logic [DW-1:0]  acc_q, acc_d;
    logic [2:0]     stat_q, stat_d;
    logic [PCW-1:0] pc_q, pc_d;
    logic [OPW-1:0] ir_q, ir_d;
    logic           irv_q, irv_d;
    logic           squash_q, squash_d;
    logic           run_q, run_d;
    logic [FAW-1:0] raddr_q, raddr_d;
    logic           fwe_q, fwe_d;
    logic [FAW-1:0] fwaddr_q, fwaddr_d;
    logic [DW-1:0]  fwdata_q, fwdata_d;
    logic [CNT_W-1:0] count_q, count_d;
    // bus state
    logic           bwr_q, bwr_d;
    logic [7:0]     baddr_q, baddr_d;
    logic [31:0]    hrdata_q, hrdata_d;
    logic           hready_q;

    lafoe_op_e      dec_op;
    logic           dec_dest_file;
    logic [DW-1:0]  dec_lit;
    logic [FAW-1:0] dec_faddr;
    logic [DW-1:0]  operand;
    logic [DW-1:0]  alu_res;
    logic           alu_c, alu_lnob, alu_z, alu_upd_cz, alu_upd_z;
    logic           alu_skip;
    logic           exec;
    logic           busy;
    logic           addr_ok;
    logic [31:0]    rd_mux;

    lafoe_decode u_decode (
        .i_word      (ir_q),
        .o_op        (dec_op),
        .o_dest_file (dec_dest_file),
        .o_literal   (dec_lit),
        .o_file_addr (dec_faddr)
    );

    // a write issued last cycle lands only now; forward it
    assign operand = (fwe_q && fwaddr_q == raddr_q) ? fwdata_q
                                                    : i_file_rdata;

    lafoe_alu u_alu (
        .i_op        (dec_op),
        .i_acc       (acc_q),
        .i_literal   (dec_lit),
        .i_file_data (operand),
        .o_result    (alu_res),
        .o_carry     (alu_c),
        .o_lnob      (alu_lnob),
        .o_zero      (alu_z),
        .o_upd_cz    (alu_upd_cz),
        .o_upd_z     (alu_upd_z),
        .o_skip      (alu_skip)
    );

    assign exec    = irv_q && !squash_q;
    assign busy    = run_q || irv_q;
    assign addr_ok = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (i_haddr[7:0])
            REG_CTRL:  rd_mux[CTRL_RUN] = run_q;
            REG_STAT:
            begin
                rd_mux[2:0]     = stat_q;
                rd_mux[ST_SKIP] = squash_q;
                rd_mux[ST_BUSY] = busy;
            end
            REG_ACC:   rd_mux[DW-1:0]    = acc_q;
            REG_PC:    rd_mux[PCW-1:0]   = pc_q;
            REG_COUNT: rd_mux[CNT_W-1:0] = count_q;
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        bwr_d    = addr_ok && i_hwrite;
        baddr_d  = addr_ok ? i_haddr[7:0] : baddr_q;
        hrdata_d = (addr_ok && !i_hwrite) ? rd_mux : hrdata_q;
    end

    always_comb
    begin
        acc_d    = acc_q;
        stat_d   = stat_q;
        pc_d     = pc_q;
        ir_d     = ir_q;
        irv_d    = 1'b0;
        squash_d = squash_q;
        run_d    = run_q;
        raddr_d  = raddr_q;
        fwe_d    = 1'b0;
        fwaddr_d = fwaddr_q;
        fwdata_d = fwdata_q;
        count_d  = count_q;
        // fetch overlaps execute of the previous word
        if (run_q)
        begin
            ir_d    = i_prog_word;
            irv_d   = 1'b1;
            pc_d    = PCW'(pc_q + 1'b1);
            raddr_d = i_prog_word[FAW-1:0];
        end
        if (irv_q)
        begin
            count_d = CNT_W'(count_q + 1'b1);
            if (squash_q)
                squash_d = 1'b0;
            else
            begin
                if (alu_upd_cz)
                begin
                    stat_d[ST_CARRY] = alu_c;
                    stat_d[ST_LNOB]  = alu_lnob;
                end
                if (alu_upd_z)
                    stat_d[ST_ZERO] = alu_z;
                if (dec_dest_file)
                begin
                    fwe_d    = 1'b1;
                    fwaddr_d = dec_faddr;
                    fwdata_d = alu_res;
                end
                else if (dec_op != OP_NO_OPERATION)
                    acc_d = alu_res;
                squash_d = alu_skip;
            end
        end
        // bus writes; state writes ignored while the pipe is live
        if (bwr_q)
        begin
            case (baddr_q)
                REG_CTRL: run_d = i_hwdata[CTRL_RUN];
                REG_STAT: if (!busy) stat_d = i_hwdata[2:0];
                REG_ACC:  if (!busy) acc_d = i_hwdata[DW-1:0];
                REG_PC:
                    if (!busy)
                    begin
                        pc_d     = i_hwdata[PCW-1:0];
                        squash_d = 1'b0;
                    end
                default:  run_d = run_q;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            acc_q    <= ACC_RST;
            stat_q   <= STAT_RST;
            pc_q     <= '0;
            ir_q     <= '0;
            irv_q    <= 1'b0;
            squash_q <= 1'b0;
            run_q    <= RUN_RST;
            raddr_q  <= '0;
            fwe_q    <= 1'b0;
            fwaddr_q <= '0;
            fwdata_q <= '0;
            count_q  <= '0;
            bwr_q    <= 1'b0;
            baddr_q  <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
        end
        else
        begin
            acc_q    <= acc_d;
            stat_q   <= stat_d;
            pc_q     <= pc_d;
            ir_q     <= ir_d;
            irv_q    <= irv_d;
            squash_q <= squash_d;
            run_q    <= run_d;
            raddr_q  <= raddr_d;
            fwe_q    <= fwe_d;
            fwaddr_q <= fwaddr_d;
            fwdata_q <= fwdata_d;
            count_q  <= count_d;
            bwr_q    <= bwr_d;
            baddr_q  <= baddr_d;
            hrdata_q <= hrdata_d;
            hready_q <= 1'b1;
        end
    end

    assign o_hrdata     = hrdata_q;
    assign o_hreadyout  = hready_q;
    assign o_hresp      = HRESP_OKAY;
    assign o_prog_addr  = pc_q;
    assign o_file_raddr = raddr_q;
    assign o_file_we    = fwe_q;
    assign o_file_waddr = fwaddr_q;
    assign o_file_wdata = fwdata_q;
    assign o_acc        = acc_q;
    assign o_status     = stat_q;

    // checking helpers
    logic [DW:0]   chk_sum_lit, chk_sum_reg;
    logic          chk_reg_op;
    assign chk_sum_lit = {1'b0, acc_q} + {1'b0, dec_lit};
    assign chk_sum_reg = {1'b0, acc_q} + {1'b0, operand};
    assign chk_reg_op  = exec && !ir_q[OPW-1] && dec_op != OP_NO_OPERATION;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence s_zero_inc;
        exec && dec_op == OP_INCREMENT_SKIP_IF_NULL && alu_skip;
    endsequence
    sequence s_next_dropped;
        irv_q && !exec ##1 !squash_q;
    endsequence

    a_add_imm_sum: assert property (
        exec && dec_op == OP_ADD_IMMEDIATE_ACC |=>
        {stat_q[ST_CARRY], acc_q} == $past(chk_sum_lit))
        else $error("immediate add sum or carry wrong");
    a_and_imm_zero: assert property (
        exec && dec_op == OP_AND_IMMEDIATE_ACC |=>
        acc_q == ($past(acc_q) & $past(dec_lit)) &&
        stat_q[ST_ZERO] == (acc_q == 8'h00) &&
        stat_q[1:0] == $past(stat_q[1:0]))
        else $error("immediate and result or flags wrong");
    a_or_imm_zero: assert property (
        exec && dec_op == OP_OR_IMMEDIATE_ACC |=>
        acc_q == ($past(acc_q) | $past(dec_lit)) &&
        stat_q[ST_ZERO] == (acc_q == 8'h00) &&
        stat_q[1:0] == $past(stat_q[1:0]))
        else $error("immediate or result or flags wrong");
    a_load_imm_flags: assert property (
        exec && dec_op == OP_LOAD_IMMEDIATE_ACC |=>
        acc_q == $past(dec_lit) && $stable(stat_q))
        else $error("load immediate wrong or flags moved");
    a_add_reg_carry: assert property (
        exec && dec_op == OP_ADD_ACC_REGISTER |=>
        stat_q[ST_CARRY] == $past(chk_sum_reg[DW]) &&
        stat_q[ST_ZERO] == ($past(chk_sum_reg[DW-1:0]) == 8'h00))
        else $error("register add flags wrong");
    a_and_reg_write: assert property (
        exec && dec_op == OP_AND_ACC_REGISTER && dec_dest_file |=>
        o_file_wdata == ($past(acc_q) & $past(operand)))
        else $error("register and result wrong");
    a_or_reg_zero: assert property (
        exec && dec_op == OP_OR_ACC_REGISTER |=>
        stat_q[ST_ZERO] == (($past(acc_q) | $past(operand)) == 8'h00))
        else $error("register or zero flag wrong");
    a_inc_flags_keep: assert property (
        exec && dec_op == OP_INCREMENT_SKIP_IF_NULL |=>
        $stable(stat_q))
        else $error("increment changed a status flag");
    a_skip_drops_next: assert property (
        s_zero_inc ##1 irv_q |-> s_next_dropped)
        else $error("word after zero increment not discarded");
    a_dest_select: assert property (
        chk_reg_op |=> o_file_we == $past(ir_q[DEST_BIT]) &&
        (o_file_we || acc_q == $past(alu_res)))
        else $error("register op destination wrong");
    a_single_cycle: assert property (
        exec && !alu_skip |=> !squash_q)
        else $error("non-skip instruction took extra cycle");
    a_dontcare_match: assert property (
        ir_q[13:9] == 5'h1F |-> dec_op == OP_ADD_IMMEDIATE_ACC)
        else $error("don't-care bit changed decode");

endmodule
`default_nettype wire

// file: src/lafoe_pkg.sv
// constants, opcode patterns and register map of the literal and file
// operation executor; shared by the executor, its decoder and its alu.
// Overview of operation
// - add immediate: acc plus literal, all three flags
// - and immediate: acc and literal, zero only
// - or immediate: acc or literal, zero only
// - load immediate into acc, flags untouched
// - add register: acc plus file, all three flags
// - and register: acc and file, zero only
// - or register: acc or file, zero only
// - increment register to destination, flags untouched
// - zero increment result squashes next fetched word
// - destination bit: 0 acc, 1 file register
package lafoe_pkg;

    localparam int OPW = 14;
    localparam int DW  = 8;
    localparam int FAW = 7;

    // instruction word fields
    localparam int DEST_BIT = 7;

    // opcode patterns, ? marks don't-care bits
    localparam logic [OPW-1:0] PAT_ADD_IMM  = 14'b11_111?_????_????;
    localparam logic [OPW-1:0] PAT_AND_IMM  = 14'b11_1001_????_????;
    localparam logic [OPW-1:0] PAT_OR_IMM   = 14'b11_1000_????_????;
    localparam logic [OPW-1:0] PAT_LOAD_IMM = 14'b11_00??_????_????;
    localparam logic [OPW-1:0] PAT_ADD_REG  = 14'b00_0111_????_????;
    localparam logic [OPW-1:0] PAT_AND_REG  = 14'b00_0101_????_????;
    localparam logic [OPW-1:0] PAT_OR_REG   = 14'b00_0100_????_????;
    localparam logic [OPW-1:0] PAT_INC_SKIP = 14'b00_1111_????_????;

    typedef enum logic [3:0] {
        OP_NO_OPERATION,
        OP_ADD_IMMEDIATE_ACC,
        OP_AND_IMMEDIATE_ACC,
        OP_OR_IMMEDIATE_ACC,
        OP_LOAD_IMMEDIATE_ACC,
        OP_ADD_ACC_REGISTER,
        OP_AND_ACC_REGISTER,
        OP_OR_ACC_REGISTER,
        OP_INCREMENT_SKIP_IF_NULL
    } lafoe_op_e;

    // register map, byte offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_STAT  = 8'h04;
    localparam logic [7:0] REG_ACC   = 8'h08;
    localparam logic [7:0] REG_PC    = 8'h0C;
    localparam logic [7:0] REG_COUNT = 8'h10;

    // field positions
    localparam int CTRL_RUN  = 0;
    localparam int ST_CARRY  = 0;
    localparam int ST_LNOB   = 1;
    localparam int ST_ZERO   = 2;
    localparam int ST_SKIP   = 8;
    localparam int ST_BUSY   = 9;

    // reset values
    localparam logic [DW-1:0] ACC_RST  = 8'h00;
    localparam logic [2:0]    STAT_RST = 3'h0;
    localparam logic          RUN_RST  = 1'b0;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// file: src/lafoe_decode.sv
// instruction decoder: maps a 14-bit word onto an operation.
// assumes the word is stable for the cycle; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module lafoe_decode
    import lafoe_pkg::*;
(
    input  wire logic [OPW-1:0] i_word,
    output var  lafoe_op_e      o_op,
    output logic                o_dest_file,
    output logic [DW-1:0]       o_literal,
    output logic [FAW-1:0]      o_file_addr
);

    always_comb
    begin
        // casez: don't-care bits match either value
        casez (i_word)
            PAT_ADD_IMM:  o_op = OP_ADD_IMMEDIATE_ACC;
            PAT_AND_IMM:  o_op = OP_AND_IMMEDIATE_ACC;
            PAT_OR_IMM:   o_op = OP_OR_IMMEDIATE_ACC;
            PAT_LOAD_IMM: o_op = OP_LOAD_IMMEDIATE_ACC;
            PAT_ADD_REG:  o_op = OP_ADD_ACC_REGISTER;
            PAT_AND_REG:  o_op = OP_AND_ACC_REGISTER;
            PAT_OR_REG:   o_op = OP_OR_ACC_REGISTER;
            PAT_INC_SKIP: o_op = OP_INCREMENT_SKIP_IF_NULL;
            default:      o_op = OP_NO_OPERATION;
        endcase
    end

    // literal ops have no destination bit; only register ops use it
    assign o_dest_file = i_word[DEST_BIT] && (i_word[OPW-1] == 1'b0)
                         && (o_op != OP_NO_OPERATION);
    assign o_literal   = i_word[DW-1:0];
    assign o_file_addr = i_word[FAW-1:0];

endmodule
`default_nettype wire

// file: src/lafoe_alu.sv
// 8-bit alu of the executor: result, flag values and flag update
// enables per operation; combinational.
`timescale 1ns/1ps
`default_nettype none
module lafoe_alu
    import lafoe_pkg::*;
(
    input  wire lafoe_op_e      i_op,
    input  wire logic [DW-1:0]  i_acc,
    input  wire logic [DW-1:0]  i_literal,
    input  wire logic [DW-1:0]  i_file_data,
    output logic [DW-1:0]       o_result,
    output logic                o_carry,
    output logic                o_lnob,
    output logic                o_zero,
    output logic                o_upd_cz,
    output logic                o_upd_z,
    output logic                o_skip
);

    logic [DW-1:0] operand;
    logic [DW:0]   sum;
    logic [4:0]    low_sum;

    always_comb
    begin
        operand  = (i_op == OP_ADD_IMMEDIATE_ACC) ? i_literal : i_file_data;
        sum      = {1'b0, i_acc} + {1'b0, operand};
        low_sum  = {1'b0, i_acc[3:0]} + {1'b0, operand[3:0]};
        o_result = i_acc;
        o_upd_cz = 1'b0;
        o_upd_z  = 1'b0;
        o_skip   = 1'b0;
        case (i_op)
            OP_ADD_IMMEDIATE_ACC, OP_ADD_ACC_REGISTER:
            begin
                o_result = sum[DW-1:0];
                o_upd_cz = 1'b1;
                o_upd_z  = 1'b1;
            end
            OP_AND_IMMEDIATE_ACC:
            begin
                o_result = i_acc & i_literal;
                o_upd_z  = 1'b1;
            end
            OP_OR_IMMEDIATE_ACC:
            begin
                o_result = i_acc | i_literal;
                o_upd_z  = 1'b1;
            end
            OP_LOAD_IMMEDIATE_ACC:
                o_result = i_literal;
            OP_AND_ACC_REGISTER:
            begin
                o_result = i_acc & i_file_data;
                o_upd_z  = 1'b1;
            end
            OP_OR_ACC_REGISTER:
            begin
                o_result = i_acc | i_file_data;
                o_upd_z  = 1'b1;
            end
            OP_INCREMENT_SKIP_IF_NULL:
            begin
                o_result = DW'(i_file_data + 8'h01);
                o_skip   = (o_result == 8'h00);
            end
            default:
                o_result = i_acc;
        endcase
        o_carry = sum[DW];
        o_lnob  = low_sum[4];
        o_zero  = (o_result == 8'h00);
    end

endmodule
`default_nettype wire

// file: dv/lafoe_mem_model.sv
// program memory and data register file on the far side of the core.
// assumes the bench fills prog_mem and file_mem by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module lafoe_mem_model
    import lafoe_pkg::*;
#(
    parameter int PCW = 10
)
(
    input  wire logic [PCW-1:0] i_prog_addr,
    input  wire logic           i_clk_sys,
    output logic [OPW-1:0]      o_prog_word,
    input  wire logic [FAW-1:0] i_file_raddr,
    output logic [DW-1:0]       o_file_rdata,
    input  wire logic           i_file_we,
    input  wire logic [FAW-1:0] i_file_waddr,
    input  wire logic [DW-1:0]  i_file_wdata
);
    logic [OPW-1:0] prog_mem [2**PCW];
    logic [DW-1:0]  file_mem [2**FAW];

    // same-cycle reads, as the core's fetch and operand stages expect
    assign o_prog_word  = prog_mem[i_prog_addr];
    assign o_file_rdata = file_mem[i_file_raddr];

    // plain always: the bench also preloads this array between runs
    always @(posedge i_clk_sys)
    begin
        if (i_file_we)
        begin
            file_mem[i_file_waddr] <= i_file_wdata;
        end
    end
endmodule
`default_nettype wire

// file: dv/lafoe_core_tb_top.sv
// self-checking bench of the executor core: ahb-lite master tasks and
// directed instruction scenarios against the memory model.
// assumes the core answers the register bus with hreadyout.
`timescale 1ns/1ps
`default_nettype none
module lafoe_core_tb_top;
    import lafoe_pkg::*;

    localparam int             PCW = 10;
    localparam logic [FAW-1:0] FA  = 7'h25;

    typedef struct {
        logic [OPW-1:0] word;
        logic [DW-1:0]  a0, f0;
        logic [2:0]     s0;
        logic [DW-1:0]  ea, ef;
        logic [2:0]     es;
    } lafoe_vec_s;

    // word, acc in, file in, flags in, acc out, file out, flags out
    lafoe_vec_s vec [19] = '{
        '{14'h3E15, 8'h10, 8'h00, 3'h7, 8'h25, 8'h00, 3'h0},
        '{14'h3FF0, 8'h10, 8'h00, 3'h0, 8'h00, 8'h00, 3'h5},
        '{14'h3E08, 8'h08, 8'h00, 3'h0, 8'h10, 8'h00, 3'h2},
        '{14'h395F, 8'hA3, 8'h00, 3'h7, 8'h03, 8'h00, 3'h3},
        '{14'h390F, 8'hF0, 8'h00, 3'h0, 8'h00, 8'h00, 3'h4},
        '{14'h3835, 8'h9A, 8'h00, 3'h7, 8'hBF, 8'h00, 3'h3},
        '{14'h3800, 8'h00, 8'h00, 3'h3, 8'h00, 8'h00, 3'h7},
        '{14'h305A, 8'h00, 8'h00, 3'h5, 8'h5A, 8'h00, 3'h5},
        '{14'h3300, 8'h77, 8'h00, 3'h2, 8'h00, 8'h00, 3'h2},
        '{14'h31A5, 8'h00, 8'h00, 3'h0, 8'hA5, 8'h00, 3'h0},
        '{14'h0725, 8'h17, 8'hC2, 3'h7, 8'hD9, 8'hC2, 3'h0},
        '{14'h07A5, 8'h80, 8'h80, 3'h0, 8'h80, 8'h00, 3'h5},
        '{14'h05A5, 8'h17, 8'hC2, 3'h7, 8'h17, 8'h02, 3'h3},
        '{14'h0525, 8'h0F, 8'hF0, 3'h0, 8'h00, 8'hF0, 3'h4},
        '{14'h0425, 8'h91, 8'h13, 3'h7, 8'h93, 8'h13, 3'h3},
        '{14'h04A5, 8'h00, 8'h00, 3'h3, 8'h00, 8'h00, 3'h7},
        '{14'h0FA5, 8'h33, 8'h41, 3'h5, 8'h33, 8'h42, 3'h5},
        '{14'h0F25, 8'h00, 8'h7F, 3'h2, 8'h80, 8'h7F, 3'h2},
        '{14'h0FA5, 8'h33, 8'hFF, 3'h0, 8'h33, 8'h00, 3'h0}
    };

    logic           clk;
    logic           rst;
    logic           hsel;
    logic [31:0]    haddr;
    logic [1:0]     htrans;
    logic           hwrite;
    logic [31:0]    hwdata;
    logic [31:0]    hrdata;
    logic           hready;
    logic           hresp;
    logic [PCW-1:0] prog_addr;
    logic [OPW-1:0] prog_word;
    logic [FAW-1:0] raddr;
    logic [DW-1:0]  rdata;
    logic           fwe;
    logic [FAW-1:0] waddr;
    logic [DW-1:0]  wdata;
    logic [DW-1:0]  acc;
    logic [2:0]     status;
    int             bad_count;
    int             checks_done;

    lafoe_core #(.PCW(PCW), .CNT_W(16)) u_dut (
        .i_clk_sys    (clk),
        .i_reset      (rst),
        .i_hsel       (hsel),
        .i_haddr      (haddr),
        .i_htrans     (htrans),
        .i_hwrite     (hwrite),
        .i_hsize      (3'h2),
        .i_hwdata     (hwdata),
        .i_hready     (hready),
        .o_hrdata     (hrdata),
        .o_hreadyout  (hready),
        .o_hresp      (hresp),
        .o_prog_addr  (prog_addr),
        .i_prog_word  (prog_word),
        .o_file_raddr (raddr),
        .i_file_rdata (rdata),
        .o_file_we    (fwe),
        .o_file_waddr (waddr),
        .o_file_wdata (wdata),
        .o_acc        (acc),
        .o_status     (status)
    );

    lafoe_mem_model #(.PCW(PCW)) u_mem (
        .i_prog_addr  (prog_addr),
        .i_clk_sys    (clk),
        .o_prog_word  (prog_word),
        .i_file_raddr (raddr),
        .o_file_rdata (rdata),
        .i_file_we    (fwe),
        .i_file_waddr (waddr),
        .i_file_wdata (wdata)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one single transfer; request held until hready is seen high
    task automatic bus_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
    endtask

    // no fixed run length: stop once the fetch passes the program
    task automatic run_prog(input int n);
        logic [31:0] rd;
        bus_xfer(1'b1, REG_PC, 32'h0, rd);
        bus_xfer(1'b1, REG_CTRL, 32'h1, rd);
        while (prog_addr < n) @(posedge clk);
        bus_xfer(1'b1, REG_CTRL, 32'h0, rd);
        do bus_xfer(1'b0, REG_STAT, 32'h0, rd); while (rd[ST_BUSY]);
    endtask

    task automatic test_bus();
        logic [31:0] rd;
        bus_xfer(1'b0, REG_ACC, 32'h0, rd);
        check(rd, {24'h0, ACC_RST}, "acc after reset");
        bus_xfer(1'b0, REG_STAT, 32'h0, rd);
        check({29'h0, rd[2:0]}, {29'h0, STAT_RST}, "flags after reset");
        bus_xfer(1'b1, 8'h20, 32'hFFFFFFFF, rd);
        bus_xfer(1'b0, 8'h20, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        $display("test bus done");
    endtask

    task automatic test_ops();
        logic [31:0] rd;
        foreach (vec[i])
        begin
            u_mem.prog_mem[0] = vec[i].word;
            u_mem.file_mem[FA] = vec[i].f0;
            bus_xfer(1'b1, REG_ACC, {24'h0, vec[i].a0}, rd);
            bus_xfer(1'b1, REG_STAT, {29'h0, vec[i].s0}, rd);
            run_prog(3);
            bus_xfer(1'b0, REG_ACC, 32'h0, rd);
            check(rd, {24'h0, vec[i].ea}, "acc");
            bus_xfer(1'b0, REG_STAT, 32'h0, rd);
            check({29'h0, rd[2:0]}, {29'h0, vec[i].es}, "flags");
            check({29'h0, status}, {29'h0, vec[i].es}, "status pins");
            check({24'h0, u_mem.file_mem[FA]}, {24'h0, vec[i].ef},
                  "file");
        end
        u_mem.prog_mem[0] = 14'h0000;
        $display("test ops done");
    endtask

    // acc must step once per cycle; the zero increment costs two
    task automatic test_timing();
        logic [DW-1:0] ex [5] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h03};
        logic [OPW-1:0] pw [5] = '{14'h3001, 14'h3002, 14'h0F10,
                                    14'h380F, 14'h3003};
        logic [31:0] rd;
        logic [31:0] c0;
        int n;
        foreach (pw[i]) u_mem.prog_mem[i] = pw[i];
        u_mem.file_mem[7'h10] = 8'hFF;
        bus_xfer(1'b1, REG_ACC, 32'h55, rd);
        bus_xfer(1'b1, REG_STAT, 32'h0, rd);
        bus_xfer(1'b1, REG_PC, 32'h0, rd);
        bus_xfer(1'b0, REG_COUNT, 32'h0, c0);
        bus_xfer(1'b1, REG_CTRL, 32'h1, rd);
        n = 0;
        while (acc !== 8'h01 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check({24'h0, acc}, {24'h0, ex[0]}, "first load");
        for (int k = 1; k < 5; k++)
        begin
            @(posedge clk);
            #1;
            check({24'h0, acc}, {24'h0, ex[k]}, "acc step");
        end
        bus_xfer(1'b1, REG_CTRL, 32'h0, rd);
        do bus_xfer(1'b0, REG_STAT, 32'h0, rd); while (rd[ST_BUSY]);
        check({29'h0, rd[2:0]}, 32'h0, "flags kept");
        check({24'h0, u_mem.file_mem[7'h10]}, 32'hFF, "file kept");
        // every fetched slot retires once, squashed ones included
        bus_xfer(1'b0, REG_COUNT, 32'h0, rd);
        c0 = rd - c0;
        bus_xfer(1'b0, REG_PC, 32'h0, rd);
        check(c0, rd, "retired vs fetched");
        foreach (pw[i]) u_mem.prog_mem[i] = 14'h0000;
        $display("test timing done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        bad_count = 0;
        checks_done = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        for (int i = 0; i < 2**PCW; i++) u_mem.prog_mem[i] = 14'h0000;
        for (int i = 0; i < 2**FAW; i++) u_mem.file_mem[i] = 8'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_bus();
        test_ops();
        test_timing();
        close_out();
    end
endmodule
`default_nettype wire
